// [bench/dual_reload_timer_block_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, s) begin total_checks++; if ((e) !== (s)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, e, s); end end
module dual_reload_timer_block_bench;
    import timer_pkg::*;
    typedef struct {logic [DATA_W-1:0] exp; logic [DATA_W-1:0] msk; logic err;} note_t;
    logic              clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd;
    logic              pready, pslverr, pa_o, pa_oe_n, irq_a, irq_b, pa_m, pb_m;
    logic              lvl_a = 1'b0, lvl_b = 1'b0, fa, fb;
    logic [2:0]        mode;
    logic [31:0]       seed = 32'd84789;
    logic [15:0]       ra, rb;
    int                n_mismatch = 0, total_checks = 0, c0, c1;
    note_t             nt;
    note_t             notes[$];
    wire logic         pa_w = pa_oe_n ? pa_m : pa_o;

    dual_reload_timer_block DUT (.clock_i(clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .timer_pin_a_i(pa_w),
        .timer_pin_a_o(pa_o), .timer_pin_a_oe_n_o(pa_oe_n), .timer_pin_b_i(pb_m),
        .irq_a_o(irq_a), .irq_b_o(irq_b));
    timer_pins_model pins (.clock_i(clk), .lvl_a_i(lvl_a), .lvl_b_i(lvl_b),
        .pin_a_o(pa_m), .pin_b_o(pb_m));

    initial forever #10 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin n_mismatch++; report_and_stop(); end
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, m,
                       input logic err);
        notes.push_back('{e, m, err});
        apb(1'b0, a, 32'h0);
    endtask : rdc

    task automatic set_pins(input logic a, input logic b);
        lvl_a <= a; lvl_b <= b;
        repeat (8) @(posedge clk);
    endtask : set_pins

    // Cycles until pin A output changes, 200 when it holds
    task automatic gap(output int c);
        logic p;
        c = 0;
        p = pa_o;
        while (pa_o === p && c < 200) begin @(posedge clk); c++; end
    endtask : gap

    always @(posedge clk) if (psel && penable && pready && !pwrite && notes.size() > 0) begin
        nt = notes.pop_front();
        `CHK("prdata", nt.exp & nt.msk, prdata & nt.msk)
        `CHK("pslverr", nt.err, pslverr)
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rdc(OFF_CTRL, 32'h0, 32'hFF, 1'b0);
        rdc(OFF_SPEED, 32'h0, 32'hFFFFFFFF, 1'b0);
        rdc(8'h1C, 32'h0, 32'hFFFFFFFF, 1'b1);
        wr(OFF_CTRL_SET, 32'h20);
        rdc(OFF_CTRL, 32'h20, 32'hFF, 1'b0);
        wr(OFF_CTRL_CLR, 32'h20);
        rdc(OFF_CTRL, 32'h0, 32'hFF, 1'b0);
        $display("test registers done");
        seed = lfsr(seed); ra = 16'(2 + seed[2:0]);
        seed = lfsr(seed); rb = 16'(2 + seed[2:0]);
        // Timer stopped while counter and reloads are written
        wr(OFF_COUNT, 32'h0);
        wr(OFF_RELOAD_A, 32'(ra));
        wr(OFF_RELOAD_B, 32'(rb));
        wr(OFF_SPEED, 32'h1);
        wr(OFF_CTRL, 32'hA0 | 32'({MODE_PWM_TOGGLE, 1'b1}));
        gap(c0);
        gap(c0);
        gap(c1);
        `CHK("gap_a", 32'(ra) + 1, 32'(c0))
        `CHK("gap_b", 32'(rb) + 1, 32'(c1))
        rdc(OFF_CTRL, 32'h50, 32'h50, 1'b0);
        `CHK("irq_a", 1'b1, irq_a)
        `CHK("irq_b", 1'b1, irq_b)
        wr(OFF_CTRL_CLR, 32'hA0);
        repeat (3) @(posedge clk);
        `CHK("irq_a_off", 1'b0, irq_a)
        `CHK("irq_b_off", 1'b0, irq_b)
        rdc(OFF_CTRL, 32'h50, 32'h50, 1'b0);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CTRL, 32'({MODE_PWM_PLAIN, 1'b1}));
        gap(c0);
        `CHK("no_toggle", 32'd200, 32'(c0))
        `CHK("oe_pwm", 1'b0, pa_oe_n)
        wr(OFF_CTRL, 32'({MODE_PWM_PLAIN, 1'b0}));
        apb(1'b0, OFF_COUNT, 32'h0);
        c0 = int'(rd);
        repeat (30) @(posedge clk);
        apb(1'b0, OFF_COUNT, 32'h0);
        `CHK("stopped", 32'(c0), rd)
        wr(OFF_SPEED, 32'h0);
        wr(OFF_COUNT, 32'h0);
        wr(OFF_CTRL, 32'({MODE_PWM_TOGGLE, 1'b1}));
        gap(c0);
        gap(c0);
        `CHK("gap_slow", 32'((ra + 1) * TC_RATIO), 32'(c0))
        wr(OFF_SPEED, 32'h1);
        $display("test pwm done");
        for (int m = 0; m < 2; m++) begin
            mode = m[0] ? MODE_EVT_FALL : MODE_EVT_RISE;
            fa = m[0];
            wr(OFF_CTRL, 32'h0);
            set_pins(fa, 1'b0);
            wr(OFF_RELOAD_A, 32'(ra));
            wr(OFF_COUNT, 32'h2);
            wr(OFF_CTRL, 32'hA0 | 32'({mode, 1'b1}));
            `CHK("oe_event", 1'b1, pa_oe_n)
            for (int k = 0; k < 3; k++) begin
                if (k == 2) rdc(OFF_CTRL, 32'h0, 32'h10, 1'b0);
                set_pins(!fa, 1'b0);
                set_pins(fa, 1'b0);
            end
            rdc(OFF_CTRL, 32'h10, 32'h10, 1'b0);
            rdc(OFF_COUNT, 32'(ra), 32'hFFFF, 1'b0);
            `CHK("irq_a_evt", 1'b1, irq_a)
            set_pins(fa, 1'b1);
            rdc(OFF_CTRL, 32'h40, 32'h40, 1'b0);
            `CHK("irq_b_evt", 1'b1, irq_b)
        end
        $display("test event done");
        for (int m = 0; m < 4; m++) begin
            mode = {m[1], 1'b1, m[0]};
            fa = mode[MODE_FALL_A];
            fb = mode[MODE_FALL_B];
            wr(OFF_CTRL, 32'h0);
            set_pins(fa, fb);
            wr(OFF_COUNT, 32'h8000);
            wr(OFF_CTRL, 32'hA0 | 32'({mode, 1'b0}));
            apb(1'b0, OFF_COUNT, 32'h0);
            c0 = int'(rd);
            set_pins(!fa, !fb);
            apb(1'b0, OFF_COUNT, 32'h0);
            c1 = int'(rd);
            `CHK("running", 1'b1, c1 < c0)
            apb(1'b0, OFF_RELOAD_A, 32'h0);
            `CHK("cap_a", 1'b1, int'(rd) < c0 && int'(rd) > c1)
            apb(1'b0, OFF_RELOAD_B, 32'h0);
            `CHK("cap_b", 1'b1, int'(rd) < c0 && int'(rd) > c1)
            rdc(OFF_CTRL, 32'h50, 32'h51, 1'b0);
            `CHK("irq_a_cap", 1'b1, irq_a)
            `CHK("irq_b_cap", 1'b1, irq_b)
            wr(OFF_CTRL_CLR, 32'h50);
            set_pins(fa, fb);
            rdc(OFF_CTRL, 32'h0, 32'h50, 1'b0);
        end
        wr(OFF_COUNT, 32'h3);
        repeat (10) @(posedge clk);
        rdc(OFF_CTRL, 32'h1, 32'h11, 1'b0);
        `CHK("irq_a_unf", 1'b1, irq_a)
        $display("test capture done");
        report_and_stop();
    end
endmodule : dual_reload_timer_block_bench

// [bench/timer_pins_model.sv]
`timescale 1ns/1ps
module timer_pins_model (
    input  wire logic clock_i,
    input  wire logic lvl_a_i,
    input  wire logic lvl_b_i,
    output logic      pin_a_o = 1'b0,
    output logic      pin_b_o = 1'b0
);
    // Pin levels change one edge after a request, like an external clocked source
    always @(posedge clock_i) begin
        pin_a_o <= lvl_a_i;
        pin_b_o <= lvl_b_i;
    end
endmodule : timer_pins_model

// [inc/timer_pkg.sv]
package timer_pkg;

    localparam int unsigned DATA_W   = 32;
    localparam int unsigned CNT_W    = 16;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned CTRL_W   = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL_SET = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL_CLR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COUNT    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_RELOAD_A = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RELOAD_B = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SPEED    = 8'h18;

    // Mode field encodings
    localparam logic [2:0] MODE_PWM_TOGGLE = 3'h5;
    localparam logic [2:0] MODE_PWM_PLAIN  = 3'h4;
    localparam logic [2:0] MODE_EVT_RISE   = 3'h0;
    localparam logic [2:0] MODE_EVT_FALL   = 3'h1;
    localparam logic [1:0] MODE_HI_PWM     = 2'h2;
    localparam logic [1:0] MODE_HI_EVT     = 2'h0;
    localparam int unsigned MODE_CAP_BIT   = 1;
    localparam int unsigned MODE_FALL_A    = 0;
    localparam int unsigned MODE_FALL_B    = 2;

    // Fast clock 50 MHz, instruction cycle one tenth of it
    localparam int unsigned FAST_CLK_MHZ   = 50;
    localparam int unsigned TC_RATIO       = 10;
    localparam logic [3:0]  TC_DIV_LAST    = 4'(TC_RATIO - 1);
    localparam logic [3:0]  TC_DIV_RESET   = 4'h0;

    localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;

    typedef struct packed {
        logic       irq_enable_b;
        logic       pending_flag_b;
        logic       irq_enable_a;
        logic       pending_flag_a;
        logic [2:0] mode;
        logic       run_or_underflow_bit;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET  = 8'h00;
    localparam logic  SPEED_RESET = 1'b0;
    localparam logic  PIN_RESET   = 1'b0;

endpackage : timer_pkg

// [src/dual_reload_timer_block.sv]
// Behaviour
// R1: One 16-bit down-counter plus 16-bit registers A and B for reload or capture.
// R2: Pulse-width counts at instruction rate, or fast clock on high-speed instances.
// R3: Pulse-width underflows reload alternately, first from A then B, repeating.
// R4: Three mode bits select pulse-width, event counting or capture edge pairs.
// R5: Toggle setting inverts pin A on every underflow; plain setting leaves it.
// R6: Pulse-width: A-reload sets pending A, B-reload sets pending B.
// R7: Pending flags stay set until software clears them.
// R8: Interrupt A or B requested when its enable and event are both present.
// R9: Event mode decrements on selected synchronised edge of pin A.
// R10: Event mode underflow sets pending A and interrupts when enable A set.
// R11: Event mode rising edge of pin B sets pending B, independent interrupt.
// R12: Event mode drives no output on pin A.
// R13: Capture mode counter runs freely; pin edges copy counter into A or B.
// R14: Capture edge polarity for pins A and B chosen independently.
// R15: Capture edges set pending A and B; enables gate the interrupts.
// R16: Capture underflow sets run bit as pending flag, sharing interrupt A.
// R17: Software clears run bit entering capture and checks both flags.
// R18: In pulse-width and event modes run bit 1 runs, 0 stops counter.
// R19: Capture registers readable anytime without disturbing the counter.
// R20: Software should stop fast timer before altering counter, reloads or pin.
// R21: Control register takes any read, write, bit set or clear safely.
// R22: Speed select 1 picks fast clock, 0 instruction clock; cleared by reset.
// R23: Counter and reload registers are not reset.
// R24: Interrupt outputs are flag AND enable, held until flag cleared.
`timescale 1ns/1ps
module dual_reload_timer_block
    import timer_pkg::*;
#(
    parameter bit HS_CAPABLE = 1'b1
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [DATA_W-1:0] pwdata_i,
    output logic      [DATA_W-1:0] prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              timer_pin_a_i,
    output logic                   timer_pin_a_o,
    output logic                   timer_pin_a_oe_n_o,
    input  wire logic              timer_pin_b_i,
    output logic                   irq_a_o,
    output logic                   irq_b_o
);

    ctrl_t             ctrl_q;
    ctrl_t             ctrl_d;
    logic              speed_q;
    logic [CNT_W-1:0]  count_q;
    logic [CNT_W-1:0]  reload_capture_reg_a;
    logic [CNT_W-1:0]  reload_capture_reg_b;
    logic              next_from_b_q;
    logic              run_prev_q;
    logic              start_pulse;
    logic              from_b;
    logic              pin_a_q;
    logic [3:0]        div_q;
    logic              tc_tick;
    logic              tick;
    logic [2:0]        sync_a_q;
    logic [2:0]        sync_b_q;
    logic              rise_a;
    logic              fall_a;
    logic              rise_b;
    logic              fall_b;
    logic              edge_a;
    logic              edge_b;
    logic              is_pwm;
    logic              is_evt;
    logic              is_cap;
    logic              dec_en;
    logic              underflow;
    logic              reload_a_ev;
    logic              reload_b_ev;
    logic              cap_a_ev;
    logic              cap_b_ev;
    logic              set_pnd_a;
    logic              set_pnd_b;
    logic              set_run;
    logic              wr_en;
    logic              rd_setup;
    logic              addr_ok;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] prdata_q;
    logic              irq_a_q;
    logic              irq_b_q;

    // APB decode, zero wait states
    assign wr_en    = psel_i & penable_i & pwrite_i;
    assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
    assign pready_o = psel_i & penable_i;

    always_comb begin
        addr_ok = 1'b1;
        rdata_d = '0;
        case (paddr_i)
            OFF_CTRL,
            OFF_CTRL_SET,
            OFF_CTRL_CLR: rdata_d[CTRL_W-1:0] = ctrl_q;
            OFF_COUNT:    rdata_d[CNT_W-1:0]  = count_q;
            OFF_RELOAD_A: rdata_d[CNT_W-1:0]  = reload_capture_reg_a; // R19
            OFF_RELOAD_B: rdata_d[CNT_W-1:0]  = reload_capture_reg_b; // R19
            OFF_SPEED:    rdata_d[0]          = speed_q;
            default:      addr_ok             = 1'b0;
        endcase
    end

    assign pslverr_o = pready_o & ~addr_ok;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= '0;
        end else if (rd_setup) begin
            prdata_q <= rdata_d;
        end
    end

    assign prdata_o = prdata_q;

    // Mode decode
    assign is_pwm = (ctrl_q.mode[2:1] == MODE_HI_PWM);                   // R4
    assign is_evt = (ctrl_q.mode[2:1] == MODE_HI_EVT);                   // R4
    assign is_cap = ctrl_q.mode[MODE_CAP_BIT];                            // R4

    // Instruction-cycle divider
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= TC_DIV_RESET;
        end else if (div_q == TC_DIV_LAST) begin
            div_q <= TC_DIV_RESET;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    assign tc_tick = (div_q == TC_DIV_LAST);
    assign tick    = (HS_CAPABLE && speed_q) ? 1'b1 : tc_tick;            // R2 R22

    // Pin synchronisers, third stage for edge detect
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a_q <= '0;
            sync_b_q <= '0;
        end else begin
            sync_a_q <= {sync_a_q[1:0], timer_pin_a_i};
            sync_b_q <= {sync_b_q[1:0], timer_pin_b_i};
        end
    end

    assign rise_a = sync_a_q[1] & ~sync_a_q[2];
    assign fall_a = ~sync_a_q[1] & sync_a_q[2];
    assign rise_b = sync_b_q[1] & ~sync_b_q[2];
    assign fall_b = ~sync_b_q[1] & sync_b_q[2];
    assign edge_a = ctrl_q.mode[MODE_FALL_A] ? fall_a : rise_a;           // R9 R14
    assign edge_b = ctrl_q.mode[MODE_FALL_B] ? fall_b : rise_b;           // R14

    // Counting events
    always_comb begin
        dec_en = 1'b0;
        if (is_pwm) begin
            dec_en = ctrl_q.run_or_underflow_bit & tick;                   // R2 R18
        end else if (is_evt) begin
            dec_en = ctrl_q.run_or_underflow_bit & edge_a;                 // R9 R18
        end else begin
            dec_en = tick;                                                 // R13
        end
    end

    // Underflow in the start cycle is the first one, so it must take A
    assign start_pulse = ctrl_q.run_or_underflow_bit & ~run_prev_q;
    assign from_b      = next_from_b_q & ~start_pulse;                      // R3
    assign underflow   = dec_en & (count_q == CNT_ZERO);
    assign reload_a_ev = underflow & ((is_pwm & ~from_b) | is_evt);         // R3
    assign reload_b_ev = underflow & is_pwm & from_b;                       // R3
    assign cap_a_ev    = is_cap & edge_a;                                  // R13
    assign cap_b_ev    = is_cap & edge_b;                                  // R13

    assign set_pnd_a = reload_a_ev | cap_a_ev;                             // R6 R10 R15
    assign set_pnd_b = reload_b_ev | cap_b_ev | (is_evt & rise_b);         // R6 R11 R15
    assign set_run   = is_cap & underflow;                                 // R16

    // Counter and reload/capture registers, not reset
    always_ff @(posedge clock_i) begin                                     // R23
        if (wr_en && paddr_i == OFF_COUNT) begin
            count_q <= pwdata_i[CNT_W-1:0];
        end else if (reload_a_ev) begin
            count_q <= reload_capture_reg_a;                               // R3
        end else if (reload_b_ev) begin
            count_q <= reload_capture_reg_b;                               // R3
        end else if (dec_en) begin
            count_q <= count_q - CNT_ONE;                                  // R1
        end
    end

    always_ff @(posedge clock_i) begin
        if (cap_a_ev) begin
            reload_capture_reg_a <= count_q;                               // R13
        end else if (wr_en && paddr_i == OFF_RELOAD_A) begin
            reload_capture_reg_a <= pwdata_i[CNT_W-1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (cap_b_ev) begin
            reload_capture_reg_b <= count_q;                               // R13
        end else if (wr_en && paddr_i == OFF_RELOAD_B) begin
            reload_capture_reg_b <= pwdata_i[CNT_W-1:0];
        end
    end

    // Control register: write, bit set, bit clear; hardware set wins
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_en) begin
            case (paddr_i)
                OFF_CTRL:     ctrl_d = ctrl_t'(pwdata_i[CTRL_W-1:0]);     // R21
                OFF_CTRL_SET: ctrl_d = ctrl_q | ctrl_t'(pwdata_i[CTRL_W-1:0]);
                OFF_CTRL_CLR: ctrl_d = ctrl_q & ~ctrl_t'(pwdata_i[CTRL_W-1:0]);
                default:      ctrl_d = ctrl_q;
            endcase
        end
        ctrl_d.pending_flag_a       = ctrl_d.pending_flag_a | set_pnd_a;   // R7
        ctrl_d.pending_flag_b       = ctrl_d.pending_flag_b | set_pnd_b;   // R7
        ctrl_d.run_or_underflow_bit = ctrl_d.run_or_underflow_bit | set_run; // R16
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            speed_q <= SPEED_RESET;                                        // R22
        end else if (wr_en && paddr_i == OFF_SPEED) begin
            speed_q <= HS_CAPABLE & pwdata_i[0];                           // R2
        end
    end

    // Reload order restarts from A on every start
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_prev_q    <= 1'b0;
            next_from_b_q <= 1'b0;
        end else begin
            run_prev_q <= ctrl_q.run_or_underflow_bit;
            if (reload_a_ev && is_pwm) begin
                next_from_b_q <= 1'b1;                                     // R3
            end else if (reload_b_ev) begin
                next_from_b_q <= 1'b0;                                     // R3
            end else if (start_pulse) begin
                next_from_b_q <= 1'b0;                                     // R3
            end
        end
    end

    // Pin A output
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_a_q <= PIN_RESET;
        end else if (is_pwm && underflow && ctrl_q.mode == MODE_PWM_TOGGLE) begin
            pin_a_q <= ~pin_a_q;                                           // R5
        end
    end

    assign timer_pin_a_o      = pin_a_q;
    assign timer_pin_a_oe_n_o = ~is_pwm;                                   // R12

    // Interrupt requests
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
        end else begin
            irq_a_q <= ctrl_q.irq_enable_a & (ctrl_q.pending_flag_a
                       | (is_cap & ctrl_q.run_or_underflow_bit));          // R8 R16 R24
            irq_b_q <= ctrl_q.irq_enable_b & ctrl_q.pending_flag_b;        // R8 R24
        end
    end

    assign irq_a_o = irq_a_q;
    assign irq_b_o = irq_b_q;

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence pwm_reload_a_s;
        is_pwm && underflow && !from_b && !wr_en;
    endsequence

    sequence pwm_reload_b_s;
        is_pwm && underflow && from_b && !wr_en;
    endsequence

    AST_PND_STICKY: assert property ( // R7
        ctrl_q.pending_flag_a && !(wr_en && (paddr_i == OFF_CTRL
            || paddr_i == OFF_CTRL_CLR)) |=> ctrl_q.pending_flag_a)
        else $error("pending A dropped without software clear");

    AST_RELOAD_A: assert property ( // R3
        pwm_reload_a_s |=> count_q == $past(reload_capture_reg_a) && next_from_b_q
            && ctrl_q.pending_flag_a)
        else $error("A reload did not load A or set pending A");

    AST_START_FROM_A: assert property ( // R3
        is_pwm && underflow && start_pulse && !wr_en
            |=> next_from_b_q && count_q == $past(reload_capture_reg_a))
        else $error("first underflow after start did not reload from A");

    AST_EVT_UNDERFLOW: assert property ( // R10
        is_evt && underflow && !wr_en
            |=> ctrl_q.pending_flag_a && count_q == $past(reload_capture_reg_a))
        else $error("event underflow did not reload A or set pending A");

    AST_RELOAD_B: assert property ( // R6
        pwm_reload_b_s |=> count_q == $past(reload_capture_reg_b)
            && ctrl_q.pending_flag_b)
        else $error("B reload did not load B or set pending B");

    AST_TOGGLE: assert property ( // R5
        is_pwm && underflow && ctrl_q.mode == MODE_PWM_TOGGLE
            |=> timer_pin_a_o != $past(timer_pin_a_o))
        else $error("pin A did not toggle on underflow");

    AST_NO_TOGGLE: assert property ( // R5
        ctrl_q.mode == MODE_PWM_PLAIN ##1 ctrl_q.mode == MODE_PWM_PLAIN
            |-> $stable(timer_pin_a_o))
        else $error("pin A changed without toggle setting");

    AST_STOPPED: assert property ( // R18
        (is_pwm || is_evt) && !ctrl_q.run_or_underflow_bit && !wr_en
            |=> $stable(count_q))
        else $error("stopped counter moved");

    AST_CAPTURE_A: assert property ( // R13
        cap_a_ev |=> reload_capture_reg_a == $past(count_q)
            && ctrl_q.pending_flag_a)
        else $error("capture A missed counter value");

    AST_CAPTURE_B: assert property ( // R13
        cap_b_ev |=> reload_capture_reg_b == $past(count_q)
            && ctrl_q.pending_flag_b)
        else $error("capture B missed counter value");

    AST_CAP_UNDERFLOW: assert property ( // R16
        set_run |=> ctrl_q.run_or_underflow_bit ##1
            (irq_a_o || !$past(ctrl_q.irq_enable_a)))
        else $error("capture underflow not flagged on interrupt A");

    AST_EVT_PIN_B: assert property ( // R11
        is_evt && rise_b |=> ctrl_q.pending_flag_b)
        else $error("pin B rise not latched in event mode");

    AST_IRQ_B: assert property ( // R24
        ctrl_q.irq_enable_b && ctrl_q.pending_flag_b |=> irq_b_o)
        else $error("interrupt B not raised");

    AST_IRQ_A: assert property ( // R8
        ctrl_q.irq_enable_a && ctrl_q.pending_flag_a |=> irq_a_o)
        else $error("interrupt A not raised");

    AST_IRQ_OFF: assert property ( // R24
        !ctrl_q.irq_enable_a && !ctrl_q.irq_enable_b |=> !irq_a_o && !irq_b_o)
        else $error("interrupt raised while disabled");

    AST_PIN_A_FREE: assert property ( // R12
        !is_pwm |-> timer_pin_a_oe_n_o)
        else $error("pin A driven outside pulse-width mode");

endmodule : dual_reload_timer_block
